/* design/slpc_pkg.sv */
package slpc_pkg;

    // ------------------------------------------------------------------
    // Register map and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0] SLEEP_CONTROL_ADDR  = 8'h00;
    localparam logic [7:0] SLEEP_CONTROL_RESET = 8'h00;
    localparam int         SLEEP_ALLOW_BIT     = 0;
    localparam int         MODE_SELECT_LSB     = 1;
    localparam int         MODE_SELECT_MSB     = 2;
    localparam logic [7:0] READ_ZERO           = 8'h00;

    // ------------------------------------------------------------------
    // Sleep mode codes
    // ------------------------------------------------------------------
    localparam logic [1:0] IDLE_CODE       = 2'h0;
    localparam logic [1:0] STANDBY_CODE    = 2'h1;
    localparam logic [1:0] POWER_DOWN_CODE = 2'h2;
    localparam logic [1:0] RESERVED_CODE   = 2'h3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    // Wake-up base time in peripheral clock cycles; clk is that clock.
    localparam int         BASE_WAKE_CYCLES = 6;
    localparam logic [2:0] BASE_WAKE_COUNT  = 3'(BASE_WAKE_CYCLES);
    localparam logic [2:0] WAKE_COUNT_FIRST = 3'h1;
    localparam logic [2:0] WAKE_COUNT_STEP  = 3'h1;

    // Brownout active-mode fuse value that holds code until the detector is ready.
    localparam logic [1:0] BROWNOUT_WAIT_CODE = 2'h3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SLPC_ACTIVE,
        SLPC_ASLEEP,
        SLPC_WAKING
    } slpc_state_t;

    // Interrupt requests that may wake the device, one bit each.
    typedef struct packed {
        logic pin_int;
        logic addr_match;
        logic tick_int;
        logic timer_b_int;
        logic usart_sof;
        logic adc_window;
        logic rtc_int;
        logic other_int;
    } slpc_src_t;

    // Run-in-standby settings of the peripherals and clock sources.
    typedef struct packed {
        logic rtc;
        logic conv_touch;
        logic usart;
        logic timer_b;
        logic main_osc;
        logic rtc_osc;
    } slpc_stby_t;

    // Clock and peripheral enables driven to the rest of the chip.
    typedef struct packed {
        logic cpu_clk;
        logic per_clk;
        logic rtc_run;
        logic adc_run;
        logic usart_run;
        logic timer_b_run;
        logic tick_run;
        logic watchdog_run;
        logic main_osc;
        logic rtc_osc;
        logic low_power_osc;
    } slpc_gate_t;

endpackage

/* design/slpc_wake_filter.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Wake source qualification per sleep mode
// ----------------------------------------------------------------------
module slpc_wake_filter (
    // Clock and reset, used by the checks only
    input  wire logic                clk,
    input  wire logic                rst,
    // Mode and configuration
    input  wire logic [1:0]          mode,
    input  wire slpc_pkg::slpc_stby_t stby,
    // Requests and result
    input  wire slpc_pkg::slpc_src_t  src,
    output logic                     wake
);

    slpc_pkg::slpc_src_t allow;
    logic [7:0]          hit;

    // Choose which requests count in the selected mode.
    always_comb begin
        allow = '0;
        case (mode)
            slpc_pkg::IDLE_CODE: begin
                allow = '1;
            end
            slpc_pkg::STANDBY_CODE: begin
                allow.pin_int     = 1'b1;
                allow.addr_match  = 1'b1;
                allow.tick_int    = 1'b1;
                allow.timer_b_int = 1'b1;
                allow.usart_sof   = stby.usart;
                allow.adc_window  = stby.conv_touch;
                allow.rtc_int     = stby.rtc;
            end
            slpc_pkg::POWER_DOWN_CODE: begin
                allow.pin_int   = 1'b1;
                allow.addr_match = 1'b1;
            end
            default: begin
                allow = '0;
            end
        endcase
    end

    // Each request is gated by its own permission bit.
    for (genvar i = 0; i < 8; i++) begin : g_gate
        assign hit[i] = src[i] & allow[i];
    end

    assign wake = |hit;

    property p_power_down_sources;
        @(posedge clk) disable iff (rst)
        (mode == slpc_pkg::POWER_DOWN_CODE && wake) |-> (src.pin_int || src.addr_match);
    endproperty
    a_power_down_sources: assert property (p_power_down_sources) else $error("Power-down woke on a barred source.");

    property p_standby_rtc;
        @(posedge clk) disable iff (rst)
        (mode == slpc_pkg::STANDBY_CODE && !stby.rtc && src == slpc_pkg::slpc_src_t'(8'h02)) |-> !wake;
    endproperty
    a_standby_rtc: assert property (p_standby_rtc) else $error("Standby woke on a stopped counter.");

    property p_idle_any;
        @(posedge clk) disable iff (rst)
        (mode == slpc_pkg::IDLE_CODE) |-> (wake == (|src));
    endproperty
    a_idle_any: assert property (p_idle_any) else $error("Idle missed an enabled request.");

endmodule // slpc_wake_filter

/* design/slpc_wake_timer.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Wake-up delay: base cycles, oscillator restart and brownout ready
// ----------------------------------------------------------------------
module slpc_wake_timer (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Sequence control
    input  wire logic start,
    input  wire logic need_osc,
    input  wire logic need_brownout,
    // Readiness from analog side
    input  wire logic osc_ready,
    input  wire logic brownout_ready,
    // Result
    output logic      done
);

    logic [2:0] count;
    logic       busy;
    logic       wait_osc;
    logic       wait_brownout;

    // Count the base cycles; the count saturates so slow sources just hold it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 3'h0;
        end else if (start) begin
            count <= slpc_pkg::WAKE_COUNT_FIRST;
        end else if (busy && count != slpc_pkg::BASE_WAKE_COUNT) begin
            count <= count + slpc_pkg::WAKE_COUNT_STEP;
        end
    end

    // Track the sequence and the conditions latched at its start.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy          <= 1'b0;
            wait_osc      <= 1'b0;
            wait_brownout <= 1'b0;
        end else if (start) begin
            busy          <= 1'b1;
            wait_osc      <= need_osc;
            wait_brownout <= need_brownout;
        end else if (done) begin
            busy <= 1'b0;
        end
    end

    // A ready detector inside the base time adds nothing; a late one extends it.
    assign done = busy && count == slpc_pkg::BASE_WAKE_COUNT
                  && (!wait_osc || osc_ready)
                  && (!wait_brownout || brownout_ready);

    property p_base_time;
        @(posedge clk) disable iff (rst)
        start |-> !done [*6];
    endproperty
    a_base_time: assert property (p_base_time) else $error("Wake finished before the base time.");

    property p_brownout_hold;
        @(posedge clk) disable iff (rst)
        (done && wait_brownout) |-> brownout_ready;
    endproperty
    a_brownout_hold: assert property (p_brownout_hold) else $error("Wake ended before brownout ready.");

    property p_fast_ready;
        @(posedge clk) disable iff (rst)
        (start && !need_osc) ##1 (brownout_ready || !wait_brownout) [*6] |-> done;
    endproperty
    a_fast_ready: assert property (p_fast_ready) else $error("Early brownout ready stretched the wake.");

endmodule // slpc_wake_timer

/* design/slpc_sleep_controller.sv */
// Design decision made here: strobed register access.
`timescale 1ns/1ps

// Contract
// - Idle stops the core clock and keeps every peripheral running.
// - Idle accepts any enabled interrupt as a wake-up.
// - Standby runs a peripheral other than tick and watchdog only when its run-in-standby bit is set.
// - Standby wakes on pin, two-wire match, timer B, tick, and enabled unit interrupts.
// - Power-down keeps only the watchdog running.
// - Power-down wakes only on pin change or two-wire address match.
// - Counter, converter, clock sources and their wakes need run-in-standby in standby.
// - Resume takes six peripheral clock cycles plus main clock restart.
// - Idle keeps the main oscillator running, so no start-up wait.
// - Standby and power-down add oscillator start-up when it was stopped.
// - Power-down keeps only the low-power and counter clocks, when brownout or watchdog use them.
// - Fuse code three holds execution until the brownout detector is ready.
// - Early brownout ready leaves wake time unchanged, late ready extends it.
// - Mode field bits 2:1: idle, standby, power-down; code three reserved.
// - Sleep is entered only when the allow bit is set and sleep executes.
// - Any reset leaves sleep.
// - A waking interrupt is serviced first, then code after sleep continues.
// - A debugger break while asleep returns to active mode.
module slpc_sleep_controller (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [7:0]                reg_rdata,
    // Core interface
    input  wire logic                 sleep_instr,
    input  wire logic                 debug_break,
    output logic                      cpu_halt,
    output logic                      resume,
    // Wake requests and configuration
    input  wire slpc_pkg::slpc_src_t  wake_src,
    input  wire slpc_pkg::slpc_stby_t run_in_standby,
    input  wire logic [1:0]           brownout_config_fuse,
    input  wire logic                 low_power_osc_req,
    input  wire logic                 rtc_clk_req,
    // Analog readiness
    input  wire logic                 main_osc_ready,
    input  wire logic                 brownout_ready,
    // Gating outputs
    output slpc_pkg::slpc_gate_t      gate
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [1:0]            sleep_mode_select;
    logic                  sleep_allow_bit;
    logic [1:0]            sleep_mode_held;
    slpc_pkg::slpc_state_t state;
    slpc_pkg::slpc_state_t next_state;
    slpc_pkg::slpc_gate_t  next_gate;
    logic                  wake_req;
    logic                  wake_start;
    logic                  wake_done;
    logic                  enter;
    logic                  mode_legal;
    logic                  need_osc;
    logic                  need_brownout;
    logic                  ctrl_hit;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    assign ctrl_hit = reg_addr == slpc_pkg::SLEEP_CONTROL_ADDR;

    // Plain write, no unlock sequence; the upper bits are not stored at all.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_allow_bit   <= slpc_pkg::SLEEP_CONTROL_RESET[slpc_pkg::SLEEP_ALLOW_BIT];
            sleep_mode_select <= slpc_pkg::SLEEP_CONTROL_RESET[slpc_pkg::MODE_SELECT_MSB:slpc_pkg::MODE_SELECT_LSB];
        end else if (reg_wr && ctrl_hit) begin
            sleep_allow_bit   <= reg_wdata[slpc_pkg::SLEEP_ALLOW_BIT];
            sleep_mode_select <= reg_wdata[slpc_pkg::MODE_SELECT_MSB:slpc_pkg::MODE_SELECT_LSB];
        end
    end

    // Read data stand one cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= slpc_pkg::READ_ZERO;
        end else if (reg_rd && ctrl_hit) begin
            reg_rdata <= {5'h00, sleep_mode_select, sleep_allow_bit};
        end else begin
            reg_rdata <= slpc_pkg::READ_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // Entry and wake decisions
    // ------------------------------------------------------------------
    // The reserved mode code is refused so the core never halts in an undefined state.
    assign mode_legal = sleep_mode_select != slpc_pkg::RESERVED_CODE;
    assign enter      = state == slpc_pkg::SLPC_ACTIVE && sleep_instr && sleep_allow_bit && mode_legal;

    // The oscillator wait applies only when the main source was really stopped.
    assign need_osc = (sleep_mode_held == slpc_pkg::STANDBY_CODE && !run_in_standby.main_osc)
                      || sleep_mode_held == slpc_pkg::POWER_DOWN_CODE;
    assign need_brownout = brownout_config_fuse == slpc_pkg::BROWNOUT_WAIT_CODE;

    slpc_wake_filter u_filter (
        .clk  (clk),
        .rst  (rst),
        .mode (sleep_mode_held),
        .stby (run_in_standby),
        .src  (wake_src),
        .wake (wake_req)
    );

    // A debugger break counts as a wake even with nothing pending.
    assign wake_start = state == slpc_pkg::SLPC_ASLEEP && (wake_req || debug_break);

    slpc_wake_timer u_timer (
        .clk       (clk),
        .rst       (rst),
        .start     (wake_start),
        .need_osc       (need_osc),
        .need_brownout  (need_brownout),
        .osc_ready      (main_osc_ready),
        .brownout_ready (brownout_ready),
        .done           (wake_done)
    );

    // Keep the mode that was entered, so late register traffic cannot alter the sleep.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_mode_held <= slpc_pkg::IDLE_CODE;
        end else if (enter) begin
            sleep_mode_held <= sleep_mode_select;
        end
    end

    // ------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            slpc_pkg::SLPC_ACTIVE: begin
                if (enter) begin
                    next_state = slpc_pkg::SLPC_ASLEEP;
                end
            end
            slpc_pkg::SLPC_ASLEEP: begin
                if (wake_start) begin
                    next_state = slpc_pkg::SLPC_WAKING;
                end
            end
            slpc_pkg::SLPC_WAKING: begin
                if (wake_done) begin
                    next_state = slpc_pkg::SLPC_ACTIVE;
                end
            end
            default: begin
                next_state = slpc_pkg::SLPC_ACTIVE;
            end
        endcase
    end

    // Reset forces active mode from any sleep.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= slpc_pkg::SLPC_ACTIVE;
        end else begin
            state <= next_state;
        end
    end

    // The core resumes one cycle after wake; it takes the pending handler first.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resume <= 1'b0;
        end else begin
            resume <= state == slpc_pkg::SLPC_WAKING && wake_done;
        end
    end

    assign cpu_halt = state != slpc_pkg::SLPC_ACTIVE;

    // ------------------------------------------------------------------
    // Clock and peripheral gating
    // ------------------------------------------------------------------
    // Gates follow the next state, so they switch in the same edge as the state.
    always_comb begin
        next_gate = '1;
        if (next_state == slpc_pkg::SLPC_ASLEEP) begin
            next_gate.cpu_clk = 1'b0;
            case (enter ? sleep_mode_select : sleep_mode_held)
                slpc_pkg::IDLE_CODE: begin
                    next_gate.cpu_clk = 1'b0;
                end
                slpc_pkg::STANDBY_CODE: begin
                    next_gate.per_clk   = 1'b0;
                    next_gate.rtc_run   = run_in_standby.rtc;
                    next_gate.adc_run     = run_in_standby.conv_touch;
                    next_gate.usart_run   = run_in_standby.usart;
                    next_gate.timer_b_run = run_in_standby.timer_b;
                    next_gate.main_osc  = run_in_standby.main_osc;
                    next_gate.rtc_osc   = run_in_standby.rtc_osc;
                end
                slpc_pkg::POWER_DOWN_CODE: begin
                    next_gate           = '0;
                    next_gate.watchdog_run  = 1'b1;
                    next_gate.low_power_osc = low_power_osc_req;
                    next_gate.rtc_osc   = rtc_clk_req;
                end
                default: begin
                    next_gate.cpu_clk = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gate <= '1;
        end else begin
            gate <= next_gate;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_entry_needs_allow;
        @(posedge clk) disable iff (rst)
        $rose(state == slpc_pkg::SLPC_ASLEEP) |-> $past(sleep_instr) && $past(sleep_allow_bit);
    endproperty
    a_entry_needs_allow: assert property (p_entry_needs_allow) else $error("Slept without allow bit.");

    property p_write_no_change;
        @(posedge clk) disable iff (rst)
        (state == slpc_pkg::SLPC_ACTIVE && reg_wr && !sleep_instr) |=> state == slpc_pkg::SLPC_ACTIVE;
    endproperty
    a_write_no_change: assert property (p_write_no_change) else $error("A write changed the power state.");

    property p_idle_gates;
        @(posedge clk) disable iff (rst)
        (state == slpc_pkg::SLPC_ASLEEP && sleep_mode_held == slpc_pkg::IDLE_CODE)
            |-> !gate.cpu_clk && gate.per_clk && gate.main_osc && gate.adc_run;
    endproperty
    a_idle_gates: assert property (p_idle_gates) else $error("Idle gating wrong.");

    property p_power_down_gates;
        @(posedge clk) disable iff (rst)
        (state == slpc_pkg::SLPC_ASLEEP && sleep_mode_held == slpc_pkg::POWER_DOWN_CODE)
            |-> gate.watchdog_run && !gate.per_clk && !gate.main_osc && !gate.rtc_run;
    endproperty
    a_power_down_gates: assert property (p_power_down_gates) else $error("Power-down gating wrong.");

    property p_standby_rtc;
        @(posedge clk) disable iff (rst)
        (state == slpc_pkg::SLPC_ASLEEP && sleep_mode_held == slpc_pkg::STANDBY_CODE && $stable(run_in_standby))
            |-> gate.rtc_run == run_in_standby.rtc && gate.main_osc == run_in_standby.main_osc;
    endproperty
    a_standby_rtc: assert property (p_standby_rtc) else $error("Standby gate ignores run setting.");

    property p_break_wakes;
        @(posedge clk) disable iff (rst)
        (state == slpc_pkg::SLPC_ASLEEP && debug_break) |=> state == slpc_pkg::SLPC_WAKING;
    endproperty
    a_break_wakes: assert property (p_break_wakes) else $error("Break did not wake.");

    property p_idle_wake_time;
        @(posedge clk) disable iff (rst)
        (wake_start && sleep_mode_held == slpc_pkg::IDLE_CODE && !need_brownout) |=> ##6 state == slpc_pkg::SLPC_ACTIVE;
    endproperty
    a_idle_wake_time: assert property (p_idle_wake_time) else $error("Idle wake not six cycles.");

    property p_resume_after_wake;
        @(posedge clk) disable iff (rst)
        resume |-> state == slpc_pkg::SLPC_ACTIVE && $past(state) == slpc_pkg::SLPC_WAKING;
    endproperty
    a_resume_after_wake: assert property (p_resume_after_wake) else $error("Resume without wake.");

    property p_reset_active;
        @(posedge clk)
        $past(rst) |-> state == slpc_pkg::SLPC_ACTIVE && !cpu_halt;
    endproperty
    a_reset_active: assert property (p_reset_active) else $error("Reset left the core halted.");

    property p_power_down_low_osc;
        @(posedge clk) disable iff (rst)
        (state == slpc_pkg::SLPC_ASLEEP && sleep_mode_held == slpc_pkg::POWER_DOWN_CODE && $stable(low_power_osc_req))
            |-> gate.low_power_osc == low_power_osc_req;
    endproperty
    a_power_down_low_osc: assert property (p_power_down_low_osc) else $error("Power-down low-power clock wrong.");

endmodule // slpc_sleep_controller

/* bench/slpc_osc_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Main oscillator start-up model
// ----------------------------------------------------------------------
module slpc_osc_model #(
    parameter int START = 10
) (
    // Clock, reset and enable
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic osc_on,
    // Readiness
    output logic      osc_ready
);
    int cnt;

    // Ready drops on the first clock edge with osc_on low, so a wake from a stopped clock is never free.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt       <= 0;
            osc_ready <= 1'b1;
        end else if (!osc_on) begin
            cnt       <= 0;
            osc_ready <= 1'b0;
        end else if (cnt < START) begin
            cnt <= cnt + 1;
        end else begin
            osc_ready <= 1'b1;
        end
    end
endmodule // slpc_osc_model

/* bench/slpc_sleep_controller_test.sv */
`timescale 1ns/1ps

module slpc_sleep_controller_test;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                 clk = 0, rst = 1, wr_s = 0, rd_s = 0, slp = 0, brk = 0, bo_rdy = 1;
    logic                 lp_req = 1, rc_req = 0;
    logic [7:0]           addr = 8'h00, wdat = 8'h00, rdat;
    logic [1:0]           fuse = 2'h0;
    logic                 osc_rdy, halt, resume;
    slpc_pkg::slpc_src_t  src = '0;
    slpc_pkg::slpc_stby_t stby = '0;
    slpc_pkg::slpc_gate_t gate;
    int                   n_fail = 0, n_tests = 0, n;

    // Free-running clock at 100 MHz.
    initial begin
        forever #5 clk = ~clk;
    end

    slpc_sleep_controller DUT (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdat), .reg_wr(wr_s),
        .reg_rd(rd_s), .reg_rdata(rdat), .sleep_instr(slp), .debug_break(brk), .cpu_halt(halt),
        .resume(resume), .wake_src(src), .run_in_standby(stby), .brownout_config_fuse(fuse),
        .low_power_osc_req(lp_req), .rtc_clk_req(rc_req), .main_osc_ready(osc_rdy),
        .brownout_ready(bo_rdy), .gate(gate));
    slpc_osc_model OSC (.clk(clk), .rst(rst), .osc_on(gate.main_osc), .osc_ready(osc_rdy));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(string what, logic [10:0] seen, logic [10:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(string w, logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(w, 11'(rdat), 11'(e));
    endtask

    task automatic sleep_go(logic h);
        @(posedge clk);
        slp <= 1'b1;
        @(posedge clk);
        slp <= 1'b0;
        #1 chk("cpu_halt", 11'(halt), 11'(h));
    endtask

    // Counts edges from raising the request until resume is seen.
    task automatic wake(logic [7:0] s, logic b, output int c);
        @(posedge clk);
        src <= s;
        brk <= b;
        c = 0;
        do begin
            @(posedge clk);
            #1 c++;
        end while (resume !== 1'b1 && c < 60);
        src <= '0;
        brk <= 1'b0;
    endtask

    task automatic no_wake(logic [7:0] s);
        @(posedge clk);
        src <= s;
        repeat (10) @(posedge clk);
        #1 chk("stay_asleep", 11'(halt), 11'h001);
        src <= '0;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reg();
        rd("ctrl_reset", 8'h00, 8'h00);
        wr(8'h00, 8'hfe);
        rd("ctrl_bits", 8'h00, 8'h06);
        rd("unmapped", 8'h01, 8'h00);
        wr(8'h00, 8'h07);
        sleep_go(1'b0);
        wr(8'h00, 8'h04);
        sleep_go(1'b0);
        wr(8'h00, 8'h01);
        repeat (4) @(posedge clk);
        #1 chk("halt_after_write", 11'(halt), 11'h000);
    endtask

    task automatic t_idle();
        sleep_go(1'b1);
        chk("idle_gate", 11'(gate), 11'h3ff);
        wake(8'h01, 1'b0, n);
        chk("idle_wake", 11'(n), 11'h007);
        chk("awake_gate", 11'(gate), 11'h7ff);
        sleep_go(1'b1);
        wake(8'h00, 1'b1, n);
        chk("break_wake", 11'(n), 11'h007);
    endtask

    task automatic t_power_down();
        wr(8'h00, 8'h05);
        sleep_go(1'b1);
        chk("pd_gate", 11'(gate), 11'h009);
        no_wake(8'h1f);
        wake(8'h40, 1'b0, n);
        chk("pd_wake_slow", 11'(n > 7 && n < 60), 11'h001);
        lp_req <= 1'b0;
        rc_req <= 1'b1;
        sleep_go(1'b1);
        chk("pd_gate_clocks", 11'(gate), 11'h00a);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1 chk("reset_halt", 11'(halt), 11'h000);
        chk("reset_gate", 11'(gate), 11'h7ff);
        rd("reset_ctrl", 8'h00, 8'h00);
    endtask

    task automatic t_stby();
        stby <= 6'h08;
        wr(8'h00, 8'h03);
        sleep_go(1'b1);
        chk("stby_gate", 11'(gate[10:1]), 11'h02c);
        no_wake(8'h07);
        no_wake(8'h02);
        wake(8'h08, 1'b0, n);
        chk("stby_wake_slow", 11'(n > 7 && n < 60), 11'h001);
    endtask

    // A late brownout ready stretches the wake; an early one changes nothing.
    task automatic t_brownout();
        fuse <= 2'h3;
        wr(8'h00, 8'h01);
        sleep_go(1'b1);
        bo_rdy <= 1'b0;
        fork
            wake(8'h80, 1'b0, n);
            begin
                repeat (14) @(posedge clk);
                bo_rdy <= 1'b1;
            end
        join
        chk("brownout_late", 11'(n > 13 && n < 18), 11'h001);
        sleep_go(1'b1);
        wake(8'h80, 1'b0, n);
        chk("brownout_early", 11'(n), 11'h007);
    endtask

    // Main sequence; a wake source is raised only after the core has gone to sleep.
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reg();
        t_idle();
        t_power_down();
        t_stby();
        t_brownout();
        close_out();
    end

    // Watchdog against a hung handshake.
    initial begin
        #100000;
        n_fail++;
        close_out();
    end
endmodule // slpc_sleep_controller_test
